// ===== rtl/usm_spi_ctrl.sv
// usart master spi control: registers, flags, buffers and pin override
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module usm_spi_ctrl
    import usm_pkg::*;
#(
    parameter int BAUD_W_P   = BAUD_W,
    parameter int RX_DEPTH_P = RX_DEPTH
) (
    // clock and reset
    input  wire logic              CLK_SYS_I,
    input  wire logic              RST_B_I,
    // register port
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [DATA_W-1:0] WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic [DATA_W-1:0]      RDATA_O,
    // interrupt handshake with the core
    input  wire logic              GIE_I,
    input  wire logic              TXC_ACK_I,
    output logic                   IRQ_RXC_O,
    output logic                   IRQ_TXC_O,
    output logic                   IRQ_UDRE_O,
    // serial pins
    output logic                   XCK_O,
    output logic                   XCK_OE_O,
    output logic                   TXD_O,
    output logic                   TXD_OE_O,
    input  wire logic              RXD_I,
    output logic                   RXD_SEL_O
);

    localparam int PTR_W = $clog2(RX_DEPTH_P);
    localparam logic [PTR_W:0] RX_FULL = (PTR_W+1)'(RX_DEPTH_P);

    // control, format and baud registers
    logic                   rxcie_reg;
    logic                   txcie_reg;
    logic                   buffer_empty_irq_enable_reg;
    logic                   rxen_reg;
    logic                   txen_reg;
    usm_mode_e              mode_reg;
    logic                   dord_reg;
    logic                   cpha_reg;
    logic                   cpol_reg;
    logic [BAUD_W_P-1:0]    baud_reg;
    // transmit side
    logic [DATA_W-1:0]      txbuf_reg;
    logic                   txbuf_full_reg;
    logic                   tx_on_reg;
    logic                   txc_reg;
    logic                   txc_next;
    // receive side
    logic [DATA_W-1:0]      rx_mem [RX_DEPTH_P];
    logic [PTR_W-1:0]       rx_wp_reg;
    logic [PTR_W-1:0]       rx_rp_reg;
    logic [PTR_W:0]         rx_cnt_reg;
    logic                   rxd_s1_reg;
    logic                   rxd_s2_reg;
    logic                   rxd_s3_reg;
    logic                   rxd_flt_reg;
    // outputs
    logic [DATA_W-1:0]      rdata_reg;
    logic [2:0]             irq_reg;
    // decoded strobes
    logic                   wr_data;
    logic                   rd_data;
    logic                   mspi;
    logic                   tx_accept;
    logic                   eng_start;
    logic                   eng_busy;
    logic                   eng_done;
    logic [DATA_W-1:0]      eng_rx;
    logic                   eng_sck;
    logic                   eng_mosi;
    logic                   push;
    logic                   pop;
    logic                   rxc;
    logic                   udre;
    logic                   txc_set;
    logic                   txc_clr;

    assign wr_data = WR_I && (ADDR_I == OFS_DATA);
    assign rd_data = RD_I && (ADDR_I == OFS_DATA);
    // only master spi mode runs frames
    assign mspi    = (mode_reg == MODE_MSPI);
    assign udre    = !txbuf_full_reg;
    assign rxc     = (rx_cnt_reg != '0);

    // ****************************************
    // serial input synchroniser
    // ****************************************
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rxd_s1_reg  <= 1'h1;
            rxd_s2_reg  <= 1'h1;
            rxd_s3_reg  <= 1'h1;
            rxd_flt_reg <= 1'h1;
        end else begin
            rxd_s1_reg <= RXD_I;
            rxd_s2_reg <= rxd_s1_reg;
            rxd_s3_reg <= rxd_s2_reg;
            // a level only counts once two stages agree
            if (rxd_s2_reg == rxd_s3_reg) begin
                rxd_flt_reg <= rxd_s3_reg;
            end
        end
    end

    // ****************************************
    // control, format and baud registers
    // ****************************************
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rxcie_reg <= CTRL_RST[B_RXCIE];
            txcie_reg <= CTRL_RST[B_TXCIE];
            buffer_empty_irq_enable_reg <= CTRL_RST[B_BUFFER_EMPTY_IRQ_ENABLE];
            rxen_reg  <= CTRL_RST[B_RXEN];
            txen_reg  <= CTRL_RST[B_TXEN];
        end else if (WR_I && (ADDR_I == OFS_CTRL)) begin
            rxcie_reg <= WDATA_I[B_RXCIE];
            txcie_reg <= WDATA_I[B_TXCIE];
            buffer_empty_irq_enable_reg <= WDATA_I[B_BUFFER_EMPTY_IRQ_ENABLE];
            rxen_reg  <= WDATA_I[B_RXEN];
            txen_reg  <= WDATA_I[B_TXEN];
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            mode_reg <= usm_mode_e'(FMT_RST[B_MODE +: 2]);
            dord_reg <= FMT_RST[B_DORD];
            cpha_reg <= FMT_RST[B_CPHA];
            cpol_reg <= FMT_RST[B_CPOL];
        end else if (WR_I && (ADDR_I == OFS_FMT)) begin
            mode_reg <= usm_mode_e'(WDATA_I[B_MODE +: 2]);
            dord_reg <= WDATA_I[B_DORD];
            cpha_reg <= WDATA_I[B_CPHA];
            cpol_reg <= WDATA_I[B_CPOL];
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            baud_reg <= BAUD_W_P'(BAUD_RST);
        end else if (WR_I && (ADDR_I == OFS_BAUD_LO)) begin
            baud_reg[7:0] <= WDATA_I;
        end else if (WR_I && (ADDR_I == OFS_BAUD_HI)) begin
            baud_reg[BAUD_W_P-1:8] <= WDATA_I[BAUD_W_P-9:0];
        end
    end

    // ****************************************
    // transmit buffer and transmitter enable
    // ****************************************
    // a data write fills the buffer when the transmitter is enabled and the buffer is empty
    assign tx_accept = wr_data && txen_reg && udre;
    assign eng_start = txbuf_full_reg && tx_on_reg && mspi && !eng_busy;

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            txbuf_reg      <= 8'h00;
            txbuf_full_reg <= 1'h0;
        end else if (tx_accept) begin
            txbuf_reg      <= WDATA_I;
            txbuf_full_reg <= 1'h1;
        end else if (eng_start) begin
            txbuf_full_reg <= 1'h0;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            tx_on_reg <= 1'h0;
        end else begin
            tx_on_reg <= txen_reg || txbuf_full_reg || eng_busy;
        end
    end

    assign txc_set  = eng_done && !txbuf_full_reg;
    // cleared by service or write one
    assign txc_clr  = TXC_ACK_I
                   || (WR_I && (ADDR_I == OFS_STAT) && WDATA_I[B_TXC]);
    assign txc_next = txc_set || (txc_reg && !txc_clr);

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            txc_reg <= 1'h0;
        end else begin
            txc_reg <= txc_next;
        end
    end

    usm_shift_engine #(
        .BAUD_W_P    (BAUD_W_P)
    ) u_engine (
        .clk_i       (CLK_SYS_I),
        .rst_b_i     (RST_B_I),
        .start_i     (eng_start),
        .tx_byte_i   (txbuf_reg),
        .baud_i      (baud_reg),
        .cpol_i      (cpol_reg),
        .cpha_i      (cpha_reg),
        .lsb_first_i (dord_reg),
        .miso_i      (rxd_flt_reg),
        .sck_o       (eng_sck),
        .mosi_o      (eng_mosi),
        .busy_o      (eng_busy),
        .done_o      (eng_done),
        .rx_byte_o   (eng_rx)
    );

    // ****************************************
    // receive buffer
    // ****************************************
    // a full buffer drops the new byte
    assign push = eng_done && rxen_reg && (rx_cnt_reg != RX_FULL);
    assign pop  = rd_data && rxc;

    always_ff @(posedge CLK_SYS_I) begin
        if (push) begin
            rx_mem[rx_wp_reg] <= eng_rx;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rx_wp_reg  <= '0;
            rx_rp_reg  <= '0;
            rx_cnt_reg <= '0;
        end else if (!rxen_reg) begin
            rx_wp_reg  <= '0;
            rx_rp_reg  <= '0;
            rx_cnt_reg <= '0;
        end else begin
            if (push) begin
                rx_wp_reg <= rx_wp_reg + PTR_W'(1);
            end
            if (pop) begin
                rx_rp_reg <= rx_rp_reg + PTR_W'(1);
            end
            if (push && !pop) begin
                rx_cnt_reg <= rx_cnt_reg + (PTR_W+1)'(1);
            end else if (pop && !push) begin
                rx_cnt_reg <= rx_cnt_reg - (PTR_W+1)'(1);
            end
        end
    end

    // ****************************************
    // interrupt requests and read port
    // ****************************************
    // enable, global enable and flag
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            irq_reg <= 3'h0;
        end else begin
            irq_reg <= {rxcie_reg && rxc, txcie_reg && txc_reg,
                        buffer_empty_irq_enable_reg && udre} & {3{GIE_I}};
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rdata_reg <= 8'h00;
        end else if (!RD_I) begin
            rdata_reg <= 8'h00;
        end else begin
            case (ADDR_I)
                OFS_DATA:    rdata_reg <= rxc ? rx_mem[rx_rp_reg] : 8'h00;
                OFS_STAT:    rdata_reg <= {rxc, txc_reg, udre, 5'h00};
                OFS_CTRL:    rdata_reg <= {rxcie_reg, txcie_reg, buffer_empty_irq_enable_reg,
                                           rxen_reg, txen_reg, 3'h0};
                OFS_FMT:     rdata_reg <= {mode_reg, 3'h0, dord_reg,
                                           cpha_reg, cpol_reg};
                OFS_BAUD_LO: rdata_reg <= baud_reg[7:0];
                OFS_BAUD_HI: rdata_reg <= 8'(baud_reg[BAUD_W_P-1:8]);
                default:     rdata_reg <= 8'h00;
            endcase
        end
    end

    assign RDATA_O    = rdata_reg;
    assign IRQ_RXC_O  = irq_reg[2];
    assign IRQ_TXC_O  = irq_reg[1];
    assign IRQ_UDRE_O = irq_reg[0];
    assign XCK_O      = eng_sck;
    assign XCK_OE_O   = tx_on_reg;
    assign TXD_O      = eng_mosi;
    assign TXD_OE_O   = tx_on_reg;
    assign RXD_SEL_O  = rxen_reg;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_B_I);

    logic [16:0] frame_cnt_reg;

    // counts busy cycles of the current frame
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            frame_cnt_reg <= 17'h00000;
        end else if (eng_start) begin
            frame_cnt_reg <= 17'h00000;
        end else if (eng_busy) begin
            frame_cnt_reg <= frame_cnt_reg + 17'h00001;
        end
    end

    sequence s_accept;
        tx_accept;
    endsequence

    sequence s_ready;
        !eng_busy && tx_on_reg && mspi;
    endsequence

    AST_RXC_DRAIN: assert property (
        pop && (rx_cnt_reg == (PTR_W+1)'(1)) && !push |=> !rxc)
        else $error("rx flag stays after last read");
    AST_RX_FLUSH: assert property (
        !rxen_reg |=> (rx_cnt_reg == '0) && !rxc)
        else $error("receive buffer not flushed");
    AST_TXC_SET: assert property (
        eng_done && !txbuf_full_reg |=> txc_reg)
        else $error("tx complete not set");
    AST_TXC_CLR: assert property (
        TXC_ACK_I && !eng_done && txc_reg |=> !txc_reg)
        else $error("tx complete not cleared");
    AST_LOAD: assert property (
        s_accept ##1 s_ready |=> eng_busy && udre)
        else $error("buffered byte not moved to shifter");
    AST_IRQ_TXC: assert property (
        IRQ_TXC_O |-> $past(txc_reg) && $past(GIE_I) && $past(txcie_reg))
        else $error("tx complete request without cause");
    AST_IRQ_RXC: assert property (
        rxc && rxcie_reg && GIE_I |=> IRQ_RXC_O)
        else $error("rx complete request missing");
    AST_IRQ_UDRE: assert property (
        !GIE_I |=> !IRQ_UDRE_O)
        else $error("buffer empty request with global enable off");
    AST_TXEN_HOLD: assert property (
        (txbuf_full_reg || eng_busy) |=> TXD_OE_O)
        else $error("serial out released with data pending");
    AST_NO_START: assert property (
        !mspi && !eng_busy |=> !eng_busy)
        else $error("frame started outside master spi mode");
    AST_OVERFLOW: assert property (
        eng_done && (rx_cnt_reg == RX_FULL) && !pop && rxen_reg
        |=> $stable(rx_wp_reg) && (rx_cnt_reg == RX_FULL))
        else $error("overflow byte was stored");
    AST_FRAME_LEN: assert property (
        $rose(eng_done) && $stable(baud_reg)
        |-> frame_cnt_reg == 17'(16 * (32'(baud_reg) + 1)))
        else $error("frame length differs from sixteen half periods");

endmodule : usm_spi_ctrl

// ===== pkg/usm_pkg.sv
// package: register map, field layout and helpers of the usart spi master
// Function
// - rx complete flag is high while the receive buffer holds unread data
// - disabling the receiver flushes the receive buffer, clearing rx complete
// - tx complete sets when frame shifted out and no byte is pending
// - tx complete clears on interrupt service or on writing one to it
// - buffer empty flag shows room for data and is set after reset
// - rx complete request needs its enable, global enable and the flag
// - tx complete request needs its enable, global enable and the flag
// - buffer empty request needs its enable, global enable and the flag
// - receiver enable turns on reception and takes over the serial input
// - clearing transmitter enable waits until shifter and buffer are empty
// - two-bit mode field: async, sync, reserved, master spi
// - order, phase and polarity are taken in the mode-select write
// - data order one sends lsb first, zero sends msb first
// - clock phase picks sampling on leading or trailing clock edge
// - clock polarity sets idle clock level; with phase gives four modes
// - a write to the data register starts a send-and-receive transfer
// - buffered byte moves to the shifter as soon as it is free
// - on receive overflow the newest byte is lost, older ones kept
package usm_pkg;

    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 3;
    localparam int BAUD_W   = 12;
    localparam int RX_DEPTH = 2;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFS_DATA    = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_STAT    = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_FMT     = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_BAUD_LO = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_BAUD_HI = 3'h5;

    // ****************************************
    // field positions
    // ****************************************
    localparam int B_RXC   = 7;
    localparam int B_TXC   = 6;
    localparam int B_UDRE  = 5;
    localparam int B_RXCIE = 7;
    localparam int B_TXCIE = 6;
    localparam int B_BUFFER_EMPTY_IRQ_ENABLE = 5;
    localparam int B_RXEN  = 4;
    localparam int B_TXEN  = 3;
    localparam int B_MODE  = 6;
    localparam int B_DORD  = 2;
    localparam int B_CPHA  = 1;
    localparam int B_CPOL  = 0;

    // ****************************************
    // reset values and timing counts
    // ****************************************
    localparam logic [DATA_W-1:0] CTRL_RST  = 8'h00;
    localparam logic [DATA_W-1:0] FMT_RST   = 8'h06;
    localparam logic [BAUD_W-1:0] BAUD_RST  = 12'h000;
    localparam logic [3:0]        EDGE_LAST = 4'hF;

    typedef enum logic [1:0] {
        MODE_ASYNC = 2'b00,
        MODE_SYNC  = 2'b01,
        MODE_RSVD  = 2'b10,
        MODE_MSPI  = 2'b11
    } usm_mode_e;

    typedef enum logic {
        ENG_IDLE  = 1'b0,
        ENG_SHIFT = 1'b1
    } usm_eng_e;

    function automatic logic out_bit(input logic [7:0] b, input logic lsb);
        out_bit = lsb ? b[0] : b[7];
    endfunction : out_bit

    function automatic logic [7:0] shift_out(input logic [7:0] b,
                                             input logic lsb);
        shift_out = lsb ? {1'h0, b[7:1]} : {b[6:0], 1'h0};
    endfunction : shift_out

    function automatic logic [7:0] shift_in(input logic [7:0] b,
                                            input logic d,
                                            input logic lsb);
        shift_in = lsb ? {d, b[7:1]} : {b[6:0], d};
    endfunction : shift_in

endpackage : usm_pkg

// ===== rtl/usm_shift_engine.sv
// transfer engine: baud divider, transfer clock and eight-bit shifter
`timescale 1ns/100ps
module usm_shift_engine
    import usm_pkg::*;
#(
    parameter int BAUD_W_P = BAUD_W
) (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    // frame request
    input  wire logic                start_i,
    input  wire logic [DATA_W-1:0]   tx_byte_i,
    input  wire logic [BAUD_W_P-1:0] baud_i,
    // format
    input  wire logic                cpol_i,
    input  wire logic                cpha_i,
    input  wire logic                lsb_first_i,
    // serial lines
    input  wire logic                miso_i,
    output logic                     sck_o,
    output logic                     mosi_o,
    // status
    output logic                     busy_o,
    output logic                     done_o,
    output logic [DATA_W-1:0]        rx_byte_o
);

    usm_eng_e              state_reg;
    logic [BAUD_W_P-1:0]   div_reg;
    logic [3:0]            edge_reg;
    logic                  lead_reg;
    logic                  sck_reg;
    logic                  mosi_reg;
    logic                  done_reg;
    logic [DATA_W-1:0]     txsh_reg;
    logic [DATA_W-1:0]     rxsh_reg;
    logic                  tick;

    // one tick per half period of the transfer clock
    assign tick = (div_reg == '0);

    // ****************************************
    // frame sequencing
    // ****************************************
    // baud divider
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= ENG_IDLE;
            div_reg   <= '0;
            edge_reg  <= 4'h0;
            done_reg  <= 1'h0;
        end else begin
            done_reg <= 1'h0;
            case (state_reg)
                ENG_IDLE: begin
                    div_reg  <= baud_i;
                    edge_reg <= 4'h0;
                    if (start_i) begin
                        state_reg <= ENG_SHIFT;
                    end
                end
                ENG_SHIFT: begin
                    if (tick) begin
                        div_reg  <= baud_i;
                        edge_reg <= edge_reg + 4'h1;
                        if (edge_reg == EDGE_LAST) begin
                            state_reg <= ENG_IDLE;
                            done_reg  <= 1'h1;
                        end
                    end else begin
                        div_reg <= div_reg - BAUD_W_P'(1);
                    end
                end
                default: state_reg <= ENG_IDLE;
            endcase
        end
    end

    // ****************************************
    // clock and data shifting
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lead_reg <= 1'h1;
            sck_reg  <= 1'h0;
            mosi_reg <= 1'h0;
            txsh_reg <= 8'h00;
            rxsh_reg <= 8'h00;
        end else if (state_reg == ENG_IDLE) begin
            sck_reg  <= cpol_i;
            lead_reg <= 1'h1;
            if (start_i) begin
                if (cpha_i) begin
                    txsh_reg <= tx_byte_i;
                end else begin
                    mosi_reg <= out_bit(tx_byte_i, lsb_first_i);
                    txsh_reg <= shift_out(tx_byte_i, lsb_first_i);
                end
            end
        end else if (tick) begin
            sck_reg  <= ~sck_reg;
            lead_reg <= ~lead_reg;
            // sample on leading or trailing edge
            if (lead_reg == cpha_i) begin
                mosi_reg <= out_bit(txsh_reg, lsb_first_i);
                txsh_reg <= shift_out(txsh_reg, lsb_first_i);
            end else begin
                rxsh_reg <= shift_in(rxsh_reg, miso_i, lsb_first_i);
            end
        end
    end

    assign sck_o     = sck_reg;
    assign mosi_o    = mosi_reg;
    assign busy_o    = (state_reg == ENG_SHIFT);
    assign done_o    = done_reg;
    assign rx_byte_o = rxsh_reg;

endmodule : usm_shift_engine

// ===== sim/usm_slave_model.sv
// spi slave model facing the serial pins of the master
`timescale 1ns/100ps
module usm_slave_model (
    input  wire logic       clk_i,
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    input  wire logic       cpha_i,
    input  wire logic       lsb_i,
    input  wire logic [7:0] rep_i,
    output logic            miso_o,
    output logic      [7:0] got_o
);
    logic       [3:0] e  = '0;
    logic       [3:0] ic = '0;
    logic             sq = '0;
    // edge count includes a toggle seen this cycle, so miso moves at once
    wire logic  [3:0] en = e + 4'(sck_i != sq);
    wire logic  [2:0] ix = 3'((en - 4'(cpha_i)) >> 1);
    // next bit shown on the shift edge
    assign miso_o = lsb_i ? rep_i[ix] : rep_i[3'h7 - ix];
    always @(posedge clk_i) begin
        sq <= sck_i;
        ic <= (sck_i != sq) ? 4'h0 : ic + 4'(ic != 4'hF);
        // no select line: a long idle clock marks the frame boundary
        e <= (ic == 4'hA && sck_i == sq) ? 4'h0 : en;
        if (sck_i != sq && e[0] == cpha_i)
            got_o <= lsb_i ? {mosi_i, got_o[7:1]} : {got_o[6:0], mosi_i};
    end
endmodule : usm_slave_model

// ===== sim/usart_master_spi_control_bench.sv
// self-checking bench of the usart master spi control
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
$display("[FAIL] %0t %h %h", $time, a, b); end end
module usart_master_spi_control_bench;
    import usm_pkg::*;
    logic       clk = '0, rst_b = '0, wr = '0, rd = '0, rd_d = '0;
    logic       gie = '0, ack = '0, pha = '0, lsb = '0;
    logic [2:0] adr = '0;
    logic [7:0] wd = '0, rep = '0, b, rdata, got;
    logic       xck, xoe, txd, toe, rxd, rsel, irx, itx, iud;
    int         errors = 0, n_compared = 0;
    logic [7:0] q[$];
    usm_spi_ctrl dut_u (.CLK_SYS_I(clk), .RST_B_I(rst_b), .ADDR_I(adr),
        .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .GIE_I(gie),
        .TXC_ACK_I(ack), .IRQ_RXC_O(irx), .IRQ_TXC_O(itx), .IRQ_UDRE_O(iud),
        .XCK_O(xck), .XCK_OE_O(xoe), .TXD_O(txd), .TXD_OE_O(toe),
        .RXD_I(rxd), .RXD_SEL_O(rsel));
    usm_slave_model sl_u (.clk_i(clk), .sck_i(xck), .mosi_i(txd),
        .cpha_i(pha), .lsb_i(lsb), .rep_i(rep), .miso_o(rxd), .got_o(got));
    initial forever #50 clk = ~clk;
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) if (rd_d) begin
        `CHK(rdata, q[0])
        void'(q.pop_front());
    end
    task automatic acc(input logic w, input logic [2:0] a,
                       input logic [7:0] d);
        if (!w) q.push_back(d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'h0;
        rd <= 1'h0;
    endtask : acc
    task automatic results();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    initial begin
        #500000;
        errors++;
        results();
    end
    initial begin
        void'($urandom(32'h3FCC7A24));
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        acc(1'h0, OFS_STAT, 8'h20);
        acc(1'h0, OFS_FMT, FMT_RST);
        acc(1'h0, 3'h7, 8'h00);
        // half period of 8 cycles leaves room for the 4-cycle input filter
        acc(1'h1, OFS_BAUD_LO, 8'h07);
        for (int m = 0; m < 8; m++) begin
            {lsb, pha} = 2'(m >> 1);
            rep = 8'($urandom);
            b = 8'($urandom);
            acc(1'h1, OFS_FMT, {2'(m % 3), 3'h0, 3'(m)});
            acc(1'h1, OFS_CTRL, 8'h18);
            acc(1'h1, OFS_DATA, b);
            repeat (12) @(posedge clk);
            acc(1'h0, OFS_STAT, 8'h00);
            acc(1'h1, OFS_FMT, {2'h3, 3'h0, 3'(m)});
            repeat (136) @(posedge clk);
            acc(1'h0, OFS_STAT, 8'hE0);
            `CHK(got, b)
            `CHK(xck, 1'(m))
            acc(1'h0, OFS_DATA, rep);
            acc(1'h1, OFS_STAT, 8'h40);
            acc(1'h0, OFS_STAT, 8'h20);
        end
        gie <= 1'h1;
        acc(1'h1, OFS_CTRL, 8'hF8);
        acc(1'h1, OFS_DATA, 8'hA5);
        acc(1'h1, OFS_CTRL, 8'hF0);
        @(negedge clk);
        `CHK(toe, 1'h1)
        repeat (140) @(posedge clk);
        `CHK({irx, itx, iud, toe, rsel}, 5'h1D)
        acc(1'h1, OFS_CTRL, 8'hE0);
        ack <= 1'h1;
        @(posedge clk);
        ack <= 1'h0;
        gie <= 1'h0;
        acc(1'h0, OFS_STAT, 8'h20);
        `CHK({irx, itx, iud, rsel}, 4'h0)
        results();
    end
endmodule : usart_master_spi_control_bench
